// *** include/tef_defs.svh ***
// Offsets, field positions, reset values and timing counts of the timer flag block
`ifndef TEF_DEFS_SVH
`define TEF_DEFS_SVH

// ==========================================================
// Register byte offsets
`define TEF_OFF_FLAGS1 8'h00
`define TEF_OFF_ENABLES1 8'h04
`define TEF_OFF_ENABLES2 8'h08
`define TEF_OFF_FLAGS2 8'h0c
`define TEF_OFF_PULSE_CTRL 8'h10
`define TEF_OFF_STATUS 8'h14

// ==========================================================
// Field positions
`define TEF_BIT_SHARED 3
`define TEF_BIT_OVF 7
`define TEF_BIT_FUNC_SEL 2
`define TEF_BIT_ST_WINDOW 0
`define TEF_BIT_ST_LOCKED 1
`define TEF_BIT_ST_IRQ 2

// ==========================================================
// Reset values
`define TEF_RST_FLAG 1'b0
`define TEF_RST_ENABLES1 8'h00
`define TEF_RST_EN2_HI 4'h0
`define TEF_RST_PRESCALE 2'b00

// ==========================================================
// Timing: prescale write window, counted in clock cycles after reset
`define TEF_PRESCALE_WINDOW 7'd64

// ==========================================================
// AXI response codes
`define TEF_RESP_OKAY 2'b00
`define TEF_RESP_SLVERR 2'b10

`endif

// *** include/tef_pkg.sv ***
// Types shared by the timer flag block
package tef_pkg;

    // Event pulses from the counter, compare and capture datapaths
    typedef struct packed {
        logic [3:0] compare_match;
        logic [2:0] capture_edge;
        logic fourth_capture_channel;
        logic fifth_compare_channel;
        logic counter_overflow;
        logic periodic_tick;
        logic pulse_count_overflow;
        logic pulse_input_edge;
    } tef_events_t;

    typedef enum logic [0:0] {TEF_WR_COLLECT, TEF_WR_RESP} tef_wr_state_t;

    typedef struct packed {
        tef_wr_state_t wr_state;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_held;
        logic w_held;
        logic [7:0] aw_addr;
        logic [7:0] w_data;
        logic w_lane0;
    } tef_bus_state_t;

    typedef struct packed {
        logic [7:0] enables1;
        logic [3:0] enables2_hi;
        logic [1:0] prescale;
        logic prescale_locked;
        logic [6:0] window_cnt;
        logic func_sel;
        logic irq;
    } tef_ctrl_state_t;

    typedef struct packed {
        tef_bus_state_t bus;
        tef_ctrl_state_t ctrl;
    } tef_state_t;

    typedef struct packed {
        logic flag;
    } tef_flag_state_t;

endpackage

// *** logic/tef_flag_cell.sv ***
// One sticky event flag, set by hardware and cleared by a write of one
`timescale 1ns/10ps
`include "tef_defs.svh"

module tef_flag_cell (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Set and clear
    input wire logic set_evt,
    input wire logic clear_req,
    // Flag
    output logic flag
);

    tef_pkg::tef_flag_state_t s_reg;
    tef_pkg::tef_flag_state_t s_next;

    // =========================================================
    // Next state: the set is applied last so it beats a clear
    always_comb begin
        s_next = s_reg;
        if (clear_req) begin
            s_next.flag = 1'b0;
        end
        if (set_evt) begin
            s_next.flag = 1'b1;
        end
    end

    // Register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg.flag <= `TEF_RST_FLAG;
        end else begin
            s_reg <= s_next;
        end
    end

    assign flag = s_reg.flag;

    // =========================================================
    // Checks
    property p_set_wins;
        @(posedge aclk) disable iff (!aresetn)
        (set_evt && clear_req) |=> flag;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

    property p_clear_one;
        @(posedge aclk) disable iff (!aresetn)
        (clear_req && !set_evt) |=> !flag;
    endproperty
    a_clear_one: assert property (p_clear_one) else $error("flag not cleared");

endmodule // tef_flag_cell

// *** logic/tef_timer_flags.sv ***
// Timer event flags, channel and interrupt enables, prescale lock, AXI4-Lite slave
//
// Contract
// - A flag clears only where software writes one; zero bits leave it.
// - Each compare match sets its compare flag, channels one to four.
// - Shared flag set by fourth capture or fifth compare, per select bit.
// - Each capture edge sets its capture flag, channels one to three.
// - Each event flag pairs with the same-position enable bit.
// - Flags stay readable whatever the enables; polled or interrupt use.
// - All eight event flags are zero after reset.
// - Second enable register is 8 bits: four enables plus prescale.
// - Overflow flag requests an interrupt only while its enable is one.
// - Normal mode: prescale written once, within 64 cycles of reset.
// - Second enable register, prescale included, is zero after reset.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "tef_defs.svh"

module tef_timer_flags (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    // Write data channel
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // Write response channel
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // Read address channel
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    // Read data channel
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Datapath events and mode
    input wire tef_pkg::tef_events_t events,
    input wire logic normal_mode,
    // Controls to the datapath
    output logic [1:0] timer_prescale_select,
    output logic shared_channel_function_select,
    // Interrupt
    output logic irq
);

    localparam int FLAG_N = 12;

    tef_pkg::tef_state_t s_reg;
    tef_pkg::tef_state_t s_next;

    logic [7:0] timer_event_flags_1;
    logic [3:0] flags2_hi;
    logic [FLAG_N-1:0] flag_q;
    logic [FLAG_N-1:0] flag_set;
    logic [FLAG_N-1:0] flag_clr;
    logic shared_set;
    logic do_write;
    logic wr_hit;
    logic window_open;
    logic prescale_ok;
    logic [7:0] rd_word;
    logic rd_hit;
    logic [7:0] timer_interrupt_enables_2;
    logic [7:0] wr_bits;

    // =========================================================
    // Event steering into the flag bits
    // Shared channel: select one picks the fourth capture, zero the fifth compare
    assign shared_set = s_reg.ctrl.func_sel ? events.fourth_capture_channel
                                            : events.fifth_compare_channel;
    // Compare channel one sits in bit 7, capture channel three in bit 0
    assign flag_set[7:0] = {events.compare_match[0], events.compare_match[1],
                            events.compare_match[2], events.compare_match[3],
                            shared_set, events.capture_edge[0],
                            events.capture_edge[1], events.capture_edge[2]};
    // Second flag group shares the layout of the second enable register
    assign flag_set[11:8] = {events.counter_overflow, events.periodic_tick,
                             events.pulse_count_overflow, events.pulse_input_edge};

    // Write-one clears, only on a full write with byte lane 0 enabled
    assign wr_bits = s_reg.bus.w_lane0 ? s_reg.bus.w_data : 8'h00;
    assign flag_clr[7:0] = (do_write && s_reg.bus.aw_addr == `TEF_OFF_FLAGS1)
                           ? wr_bits : 8'h00;
    assign flag_clr[11:8] = (do_write && s_reg.bus.aw_addr == `TEF_OFF_FLAGS2)
                            ? wr_bits[7:4] : 4'h0;

    // One cell per flag keeps the set-over-clear ordering in one place
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_N; gi++) begin : g_flag
            tef_flag_cell u_cell (
                .aclk(aclk),
                .aresetn(aresetn),
                .set_evt(flag_set[gi]),
                .clear_req(flag_clr[gi]),
                .flag(flag_q[gi])
            );
        end
    endgenerate

    assign timer_event_flags_1 = flag_q[7:0];
    assign flags2_hi = flag_q[11:8];
    assign timer_interrupt_enables_2 = {s_reg.ctrl.enables2_hi, 2'b00,
                                        s_reg.ctrl.prescale};

    // =========================================================
    // Write decode and prescale window
    assign do_write = (s_reg.bus.wr_state == tef_pkg::TEF_WR_COLLECT)
                      && s_reg.bus.aw_held && s_reg.bus.w_held;
    assign window_open = s_reg.ctrl.window_cnt < `TEF_PRESCALE_WINDOW;
    // Special modes may rewrite freely; normal mode gets one try, early only
    assign prescale_ok = !normal_mode
                         || (window_open && !s_reg.ctrl.prescale_locked);

    always_comb begin
        case (s_reg.bus.aw_addr)
            `TEF_OFF_FLAGS1, `TEF_OFF_ENABLES1, `TEF_OFF_ENABLES2,
            `TEF_OFF_FLAGS2, `TEF_OFF_PULSE_CTRL, `TEF_OFF_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // =========================================================
    // Read mux on the live read address; flags read regardless of enables
    always_comb begin
        rd_hit = 1'b1;
        case (araddr)
            `TEF_OFF_FLAGS1: rd_word = timer_event_flags_1;
            `TEF_OFF_ENABLES1: rd_word = s_reg.ctrl.enables1;
            `TEF_OFF_ENABLES2: rd_word = timer_interrupt_enables_2;
            `TEF_OFF_FLAGS2: rd_word = {flags2_hi, 4'h0};
            `TEF_OFF_PULSE_CTRL: rd_word = {5'h00, s_reg.ctrl.func_sel, 2'b00};
            `TEF_OFF_STATUS: rd_word = {5'h00, s_reg.ctrl.irq,
                                        s_reg.ctrl.prescale_locked, window_open};
            default: begin
                rd_word = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // =========================================================
    // Next state of bus slave and control registers
    always_comb begin
        s_next = s_reg;
        // Window counter saturates, so the window stays shut until the next reset
        if (window_open) begin
            s_next.ctrl.window_cnt = s_reg.ctrl.window_cnt + 7'd1;
        end
        // Interrupt level from paired flag and enable bits, registered
        s_next.ctrl.irq = (|(timer_event_flags_1 & s_reg.ctrl.enables1))
                          || (|(flags2_hi & s_reg.ctrl.enables2_hi));
        // Address and data may arrive in either order
        if (awvalid && s_reg.bus.awready) begin
            s_next.bus.aw_held = 1'b1;
            s_next.bus.aw_addr = awaddr;
        end
        if (wvalid && s_reg.bus.wready) begin
            s_next.bus.w_held = 1'b1;
            s_next.bus.w_data = wdata[7:0];
            s_next.bus.w_lane0 = wstrb[0];
        end
        if (do_write) begin
            s_next.bus.aw_held = 1'b0;
            s_next.bus.w_held = 1'b0;
            s_next.bus.wr_state = tef_pkg::TEF_WR_RESP;
            s_next.bus.bvalid = 1'b1;
            s_next.bus.bresp = wr_hit ? `TEF_RESP_OKAY : `TEF_RESP_SLVERR;
            if (s_reg.bus.w_lane0) begin
                case (s_reg.bus.aw_addr)
                    `TEF_OFF_ENABLES1: s_next.ctrl.enables1 = s_reg.bus.w_data;
                    `TEF_OFF_ENABLES2: begin
                        s_next.ctrl.enables2_hi = s_reg.bus.w_data[7:4];
                        if (prescale_ok) begin
                            s_next.ctrl.prescale = s_reg.bus.w_data[1:0];
                            s_next.ctrl.prescale_locked = normal_mode;
                        end
                    end
                    `TEF_OFF_PULSE_CTRL: begin
                        s_next.ctrl.func_sel = s_reg.bus.w_data[`TEF_BIT_FUNC_SEL];
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (s_reg.bus.bvalid && bready) begin
            s_next.bus.bvalid = 1'b0;
            s_next.bus.wr_state = tef_pkg::TEF_WR_COLLECT;
        end
        // Each channel is refused while its word is held or a response waits
        s_next.bus.awready = (s_next.bus.wr_state == tef_pkg::TEF_WR_COLLECT)
                             && !s_next.bus.aw_held;
        s_next.bus.wready = (s_next.bus.wr_state == tef_pkg::TEF_WR_COLLECT)
                            && !s_next.bus.w_held;
        // Read: one outstanding, data captured at the address handshake
        if (arvalid && s_reg.bus.arready) begin
            s_next.bus.arready = 1'b0;
            s_next.bus.rvalid = 1'b1;
            s_next.bus.rdata = {24'h000000, rd_word};
            s_next.bus.rresp = rd_hit ? `TEF_RESP_OKAY : `TEF_RESP_SLVERR;
        end
        if (s_reg.bus.rvalid && rready) begin
            s_next.bus.rvalid = 1'b0;
            s_next.bus.arready = 1'b1;
        end
        // Read ready returns on its own after reset, when no read is waiting
        if (!s_reg.bus.rvalid && !s_reg.bus.arready) begin
            s_next.bus.arready = 1'b1;
        end
    end

    // =========================================================
    // State register; ready outputs rise one edge after reset release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.bus.arready <= 1'b0;
            s_reg.ctrl.enables1 <= `TEF_RST_ENABLES1;
            s_reg.ctrl.enables2_hi <= `TEF_RST_EN2_HI;
            s_reg.ctrl.prescale <= `TEF_RST_PRESCALE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign awready = s_reg.bus.awready;
    assign wready = s_reg.bus.wready;
    assign bvalid = s_reg.bus.bvalid;
    assign bresp = s_reg.bus.bresp;
    assign arready = s_reg.bus.arready;
    assign rvalid = s_reg.bus.rvalid;
    assign rdata = s_reg.bus.rdata;
    assign rresp = s_reg.bus.rresp;
    assign timer_prescale_select = s_reg.ctrl.prescale;
    assign shared_channel_function_select = s_reg.ctrl.func_sel;
    assign irq = s_reg.ctrl.irq;

    // =========================================================
    // Checks
    logic [7:0] wr_data_q;
    assign wr_data_q = wr_bits;

    sequence s_flags1_write;
        do_write && s_reg.bus.aw_addr == `TEF_OFF_FLAGS1 && flag_set[7:0] == 8'h00;
    endsequence

    property p_w1c_keep;
        @(posedge aclk) disable iff (!aresetn)
        s_flags1_write |=> timer_event_flags_1
                           == ($past(timer_event_flags_1) & ~$past(wr_data_q));
    endproperty
    a_w1c_keep: assert property (p_w1c_keep) else $error("flag write not w1c");

    property p_compare_set;
        @(posedge aclk) disable iff (!aresetn)
        events.compare_match[0] |=> timer_event_flags_1[7];
    endproperty
    a_compare_set: assert property (p_compare_set) else $error("compare flag missed");

    property p_shared_set;
        @(posedge aclk) disable iff (!aresetn)
        (s_reg.ctrl.func_sel ? events.fourth_capture_channel
                             : events.fifth_compare_channel)
        |=> timer_event_flags_1[`TEF_BIT_SHARED];
    endproperty
    a_shared_set: assert property (p_shared_set) else $error("shared flag missed");

    property p_capture_set;
        @(posedge aclk) disable iff (!aresetn)
        events.capture_edge[2] |=> timer_event_flags_1[0];
    endproperty
    a_capture_set: assert property (p_capture_set) else $error("capture flag missed");

    property p_pair_irq;
        @(posedge aclk) disable iff (!aresetn)
        (|(timer_event_flags_1 & s_reg.ctrl.enables1)) |=> irq;
    endproperty
    a_pair_irq: assert property (p_pair_irq) else $error("paired irq missing");

    property p_ovf_irq;
        @(posedge aclk) disable iff (!aresetn)
        (!(|(timer_event_flags_1 & s_reg.ctrl.enables1))
         && !(|(flags2_hi & s_reg.ctrl.enables2_hi)))
        |=> !irq;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("irq without enable");

    property p_flags_read;
        @(posedge aclk) disable iff (!aresetn)
        (arvalid && arready && araddr == `TEF_OFF_FLAGS1)
        |=> rvalid && rdata[7:0] == $past(timer_event_flags_1);
    endproperty
    a_flags_read: assert property (p_flags_read) else $error("flag read wrong");

    property p_reset_zero;
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> timer_event_flags_1 == 8'h00
                           && timer_interrupt_enables_2 == 8'h00;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

    property p_prescale_lock;
        @(posedge aclk) disable iff (!aresetn)
        (do_write && normal_mode && s_reg.bus.aw_addr == `TEF_OFF_ENABLES2
         && (s_reg.ctrl.prescale_locked || !window_open))
        |=> $stable(timer_prescale_select);
    endproperty
    a_prescale_lock: assert property (p_prescale_lock) else $error("late prescale write");

endmodule // tef_timer_flags

// *** sim/tef_timer_flags_tb_top.sv ***
// Self-checking bench for the timer flag block, driven over AXI4-Lite
`timescale 1ns/10ps
`include "tef_defs.svh"

module tef_timer_flags_tb_top;
    // ==========================================================
    // Signals
    localparam int LIMIT = 5000;
    logic aclk;
    logic aresetn;
    logic awvalid;
    logic awready;
    logic [7:0] awaddr;
    logic wvalid;
    logic wready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic bready;
    logic [1:0] bresp;
    logic arvalid;
    logic arready;
    logic [7:0] araddr;
    logic rvalid;
    logic rready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    tef_pkg::tef_events_t events;
    tef_pkg::tef_events_t ev;
    logic normal_mode;
    logic [1:0] timer_prescale_select;
    logic shared_channel_function_select;
    logic irq;
    int error_cnt;
    int checks;
    int cycle_cnt;
    logic [31:0] rd_val;
    logic [1:0] resp;

    // ==========================================================
    // Design under test
    tef_timer_flags u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .events(events), .normal_mode(normal_mode),
        .timer_prescale_select(timer_prescale_select),
        .shared_channel_function_select(shared_channel_function_select),
        .irq(irq)
    );

    // ==========================================================
    // Clock and hang guard
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // A run far past the expected few hundred cycles means a lost handshake
    always @(posedge aclk) begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == LIMIT) begin
            error_cnt++;
            finish_test();
        end
    end

    // ==========================================================
    // Tasks
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Compare a seen value with the expected one
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // Write one byte; e is pulsed in the cycle whose edge lands the write
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input tef_pkg::tef_events_t e);
        bit aw_d;
        bit w_d;
        aw_d = 0;
        w_d = 0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wstrb <= 4'h1;
        bready <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                aw_d = 1;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                w_d = 1;
            end
        end
        events <= e;
        do begin
            @(posedge aclk);
            events <= '0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    // Read one register word and its response code
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge aclk); while (!(arvalid && arready));
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        rd_val = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // One-cycle datapath event pulse, then let flag and irq settle
    task automatic pulse(input tef_pkg::tef_events_t e);
        @(posedge aclk);
        events <= e;
        @(posedge aclk);
        events <= '0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        wstrb = 4'h0;
        events = '0;
        normal_mode = 1'b1;
        error_cnt = 0;
        checks = 0;
        cycle_cnt = 0;
        do_reset();
        // Prescale write lands early, inside the window after release
        wr(`TEF_OFF_ENABLES2, 8'h71, '0);
        chk(resp, `TEF_RESP_OKAY, "write response");
        rd(`TEF_OFF_ENABLES2);
        chk(rd_val, 32'h00000071, "enables2 first write");
        chk(timer_prescale_select, 2'h1, "prescale output");
        wr(`TEF_OFF_ENABLES2, 8'h02, '0);
        rd(`TEF_OFF_ENABLES2);
        chk(rd_val, 32'h00000001, "prescale second write ignored");
        rd(`TEF_OFF_FLAGS1);
        chk(rd_val, 32'h00000000, "flags reset");
        // Overflow flag with its enable off, then on
        ev = '0;
        ev.counter_overflow = 1'b1;
        pulse(ev);
        rd(`TEF_OFF_FLAGS2);
        chk(rd_val, 32'h00000080, "overflow flag");
        chk(irq, 1'b0, "overflow irq masked");
        wr(`TEF_OFF_ENABLES2, 8'h80, '0);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b1, "overflow irq enabled");
        wr(`TEF_OFF_FLAGS2, 8'h80, '0);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b0, "overflow irq cleared");
        wr(`TEF_OFF_ENABLES2, 8'h00, '0);
        // Compare channels one to four and capture channels one to three at once
        ev = '0;
        ev.compare_match = 4'hf;
        ev.capture_edge = 3'h7;
        pulse(ev);
        rd(`TEF_OFF_FLAGS1);
        chk(rd_val, 32'h000000f7, "compare and capture flags");
        chk(irq, 1'b0, "no irq while enables clear");
        // Zero bits leave flags, one bits clear them
        wr(`TEF_OFF_FLAGS1, 8'h00, '0);
        rd(`TEF_OFF_FLAGS1);
        chk(rd_val, 32'h000000f7, "write zero keeps flags");
        wr(`TEF_OFF_FLAGS1, 8'h81, '0);
        rd(`TEF_OFF_FLAGS1);
        chk(rd_val, 32'h00000076, "write one clears");
        // Shared flag source follows the select bit
        ev = '0;
        ev.fourth_capture_channel = 1'b1;
        pulse(ev);
        rd(`TEF_OFF_FLAGS1);
        chk(rd_val, 32'h00000076, "capture ignored when compare chosen");
        ev = '0;
        ev.fifth_compare_channel = 1'b1;
        pulse(ev);
        rd(`TEF_OFF_FLAGS1);
        chk(rd_val, 32'h0000007e, "fifth compare sets shared");
        wr(`TEF_OFF_FLAGS1, 8'h08, '0);
        wr(`TEF_OFF_PULSE_CTRL, 8'h04, '0);
        chk(shared_channel_function_select, 1'b1, "select output");
        pulse(ev);
        rd(`TEF_OFF_FLAGS1);
        chk(rd_val, 32'h00000076, "compare ignored when capture chosen");
        ev = '0;
        ev.fourth_capture_channel = 1'b1;
        pulse(ev);
        rd(`TEF_OFF_FLAGS1);
        chk(rd_val, 32'h0000007e, "fourth capture sets shared");
        // Enable in another position must not raise irq
        wr(`TEF_OFF_ENABLES1, 8'h80, '0);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b0, "unpaired enable");
        wr(`TEF_OFF_ENABLES1, 8'h08, '0);
        repeat (8) @(posedge aclk);
        chk(irq, 1'b1, "paired enable holds irq");
        // Clear and set meet on the same edge: the set wins
        wr(`TEF_OFF_FLAGS1, 8'h08, ev);
        repeat (3) @(posedge aclk);
        rd(`TEF_OFF_FLAGS1);
        chk(rd_val, 32'h0000007e, "set beats clear");
        chk(irq, 1'b1, "irq kept after lost clear");
        wr(`TEF_OFF_FLAGS1, 8'h08, '0);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b0, "irq drops after clear");
        // Unmapped offset
        rd(8'h20);
        chk(resp, `TEF_RESP_SLVERR, "unmapped response");
        chk(rd_val, 32'h00000000, "unmapped data");
        // Outside normal mode prescale stays writable
        normal_mode <= 1'b0;
        wr(`TEF_OFF_ENABLES2, 8'h03, '0);
        rd(`TEF_OFF_ENABLES2);
        chk(rd_val, 32'h00000003, "prescale in special mode");
        normal_mode <= 1'b1;
        // Second reset, then a write after the window has closed
        do_reset();
        rd(`TEF_OFF_ENABLES2);
        chk(rd_val, 32'h00000000, "enables2 reset");
        rd(`TEF_OFF_FLAGS1);
        chk(rd_val, 32'h00000000, "flags reset again");
        repeat (70) @(posedge aclk);
        wr(`TEF_OFF_ENABLES2, 8'h02, '0);
        rd(`TEF_OFF_ENABLES2);
        chk(rd_val, 32'h00000000, "late prescale ignored");
        finish_test();
    end
endmodule // tef_timer_flags_tb_top
